// ---- design/ipa_arbiter.sv ----
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "ipa_cfg.svh"
// What this block does
// - 3-bit mask blocks levels at/below it, not seven
// - seven lines are levels one to seven
// - timer and edge levels; zero disables source
// - internal and external requests wired-NOR per level
// - pins active low; level 7 needs edge
// - NMI on new level 7 or mask leaving seven
// - request valid after two consecutive samples
// - valid request waits for instruction boundary
// - pending level not latched; higher supersedes
// - acknowledged level copied into mask
// - acknowledge drives all-ones function code and address, except level on address bits 3:1
// - same level resolved by 4-bit identifier contention
// - winning identifier zero gives spurious exception
// - reset identifiers: integration one 1111, others 0000
// - integration identifier gates external acknowledge forwarding
// - no contender ends cycle with bus fault
// - winner gives vector or asks autovector
// - external answers with size ack; timeout is spurious
// - autovector derives vector from level
// - integration sources: timer, pins, then edge
// - vector fetched and loaded into program counter
// - vector base resets to zero, software writable
module ipa_arbiter
	import ipa_pkg::*;
#(
	parameter int       NMOD       = 4,
	parameter int       BUSMON_CYC = `IPA_BUSMON_CYC,
	parameter bit [7:0] SPUR_VEC   = `IPA_SPUR_VEC,
	parameter bit [7:0] AUTO_BASE  = `IPA_AUTO_BASE
)
(
	// Clock and reset
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	// APB register port
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic [31:0]               prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Request sources
	input  wire logic [7:1]           extIrqN,
	input  wire logic [NMOD-1:0]      modReq,
	input  wire logic [NMOD-1:0][2:0] modLvl,
	input  wire logic [NMOD-1:0][7:0] modVec,
	input  wire logic [NMOD-1:0]      modAvec,
	input  wire logic                 timerReq,
	input  wire logic                 edgeReq,
	// Source acknowledges
	output logic [NMOD-1:0]           modAck,
	output logic                      timerAck,
	output logic                      edgeAck,
	// Acknowledge cycle and external termination
	output ipa_ack_t                  ackBus,
	output logic                      extAckCycle,
	input  wire logic                 sizeAckN,
	input  wire logic                 autovectorReqN,
	input  wire logic                 busFaultN,
	input  wire logic [7:0]           extData,
	output logic                      busFaultOut,
	output logic                      spuriousEvt,
	// Core side
	input  wire logic                 instrBoundary,
	output ipa_fetch_t                fetch,
	input  wire logic                 fetchDone,
	input  wire logic [31:0]          fetchData,
	output logic                      pcLoad,
	output logic [31:0]               pcValue
);

	localparam int MON_BOUND = BUSMON_CYC + 2;

	ipa_state_t            stateQ;
	logic [2:0]            maskQ;
	logic [2:0]            maskPrevQ;
	logic [31:0]           vbrQ;
	logic [2:0]            tmrLvlQ;
	logic [7:0]            tmrVecQ;
	logic [2:0]            edgeLvlQ;
	logic [7:0]            edgeVecQ;
	logic [3:0]            simIdQ;
	logic [NMOD-1:0][3:0]  modIdQ;
	logic [7:1]            rawLine;
	logic [7:1]            sampleAQ;
	logic [7:1]            sampleBQ;
	logic [7:1]            lvlValid;
	logic                  valid7PrevQ;
	logic                  nmiPendQ;
	logic [2:0]            pendLvl;
	logic [2:0]            ackLevelQ;
	logic [7:0]            vecQ;
	logic [31:0]           pcValueQ;
	logic [$clog2(MON_BOUND+1)-1:0] monCntQ;
	logic                  startAck;
	logic                  tmrHit;
	logic                  extHit;
	logic                  edgeHit;
	logic                  simHit;
	logic [3:0]            winId;
	logic [NMOD-1:0]       winMod;
	logic                  simWins;
	logic                  apbSetup;
	logic                  apbWrite;

	// Internal requests join the pin levels here; pins are only read
	genvar gl;
	generate
		for (gl = 1; gl <= 7; gl++)
		begin : g_line
			logic modOn;
			always_comb
			begin
				modOn = 1'b0;
				for (int m = 0; m < NMOD; m++)
					modOn = modOn | (modReq[m] && modLvl[m] == 3'(gl));
			end
			assign rawLine[gl] = ~extIrqN[gl] | modOn
				| (timerReq && tmrLvlQ == 3'(gl))
				| (edgeReq && edgeLvlQ == 3'(gl));
		end
	endgenerate

	// Rising-edge sampling stands in for the falling-edge pair; the
	// two-sample filter is what matters for validity
	always_ff @(posedge core_clk or posedge rst)
		if (rst)
		begin
			sampleAQ <= '0;
			sampleBQ <= '0;
		end
		else
		begin
			sampleAQ <= rawLine;
			sampleBQ <= sampleAQ;
		end
	assign lvlValid = sampleAQ & sampleBQ;

	// Level 7 edge tracking; a new edge wins over the clear by acknowledge
	always_ff @(posedge core_clk or posedge rst)
		if (rst)
		begin
			valid7PrevQ <= 1'b0;
			maskPrevQ   <= `IPA_MASK_RST;
			nmiPendQ    <= 1'b0;
		end
		else
		begin
			valid7PrevQ <= lvlValid[7];
			maskPrevQ   <= maskQ;
			if ((lvlValid[7] && !valid7PrevQ) ||
				(lvlValid[7] && maskPrevQ == `IPA_LVL_NMI &&
				maskQ != `IPA_LVL_NMI))
				nmiPendQ <= 1'b1;
			else if (startAck && pendLvl == `IPA_LVL_NMI)
				nmiPendQ <= 1'b0;
		end

	// Highest live level above the mask; recomputed every cycle
	always_comb
	begin
		pendLvl = `IPA_LVL_NONE;
		for (int l = 1; l < 7; l++)
			if (lvlValid[l] && 3'(l) > maskQ)
				pendLvl = 3'(l);
		if (nmiPendQ && lvlValid[7])
			pendLvl = `IPA_LVL_NMI;
	end
	assign startAck = stateQ == S_IDLE && instrBoundary &&
		pendLvl != `IPA_LVL_NONE;

	// Contention; the widest compare equals the serial bit-by-bit walk
	assign tmrHit  = timerReq && tmrLvlQ == ackLevelQ;
	assign extHit  = ackLevelQ != `IPA_LVL_NONE && !extIrqN[ackLevelQ];
	assign edgeHit = edgeReq && edgeLvlQ == ackLevelQ;
	assign simHit  = tmrHit | extHit | edgeHit;
	always_comb
	begin
		winId   = `IPA_ID_NONE;
		winMod  = '0;
		simWins = 1'b0;
		if (simHit)
		begin
			winId   = simIdQ;
			simWins = simIdQ != `IPA_ID_NONE;
		end
		for (int m = 0; m < NMOD; m++)
			if (modReq[m] && modLvl[m] == ackLevelQ &&
				modIdQ[m] > winId)
			begin
				winId   = modIdQ[m];
				winMod  = '0;
				winMod[m] = 1'b1;
				simWins = 1'b0;
			end
	end

	// Acknowledge sequence
	always_ff @(posedge core_clk or posedge rst)
		if (rst)
		begin
			stateQ    <= S_IDLE;
			ackLevelQ <= `IPA_LVL_NONE;
			vecQ      <= SPUR_VEC;
			monCntQ   <= '0;
		end
		else
		begin
			case (stateQ)
				S_IDLE:
					if (startAck)
					begin
						ackLevelQ <= pendLvl;
						stateQ    <= S_ACK;
					end
				S_ACK:
					stateQ <= S_ARB;
				S_ARB:
				begin
					stateQ <= S_FETCH;
					if (winId == `IPA_ID_NONE)
						vecQ <= SPUR_VEC;
					else if (!simWins)
					begin
						for (int m = 0; m < NMOD; m++)
							if (winMod[m])
								vecQ <= modAvec[m] ? AUTO_BASE + 8'(ackLevelQ)
									: modVec[m];
					end
					else if (tmrHit)
						vecQ <= tmrVecQ;
					else if (extHit)
					begin
						monCntQ <= '0;
						stateQ  <= S_EXT;
					end
					else
						vecQ <= edgeVecQ;
				end
				S_EXT:
				begin
					monCntQ <= monCntQ + 1'b1;
					if (!autovectorReqN)
					begin
						vecQ   <= AUTO_BASE + 8'(ackLevelQ);
						stateQ <= S_FETCH;
					end
					else if (!sizeAckN)
					begin
						vecQ   <= extData;
						stateQ <= S_FETCH;
					end
					else if (!busFaultN ||
						monCntQ >= ($bits(monCntQ))'(BUSMON_CYC - 1))
					begin
						vecQ   <= SPUR_VEC;
						stateQ <= S_FETCH;
					end
				end
				S_FETCH:
					if (fetchDone)
						stateQ <= S_LOAD;
				S_LOAD:
					stateQ <= S_IDLE;
				default:
					stateQ <= S_IDLE;
			endcase
		end

	// Termination pulses and program counter value
	always_ff @(posedge core_clk or posedge rst)
		if (rst)
		begin
			modAck      <= '0;
			timerAck    <= 1'b0;
			edgeAck     <= 1'b0;
			spuriousEvt <= 1'b0;
			busFaultOut <= 1'b0;
			pcValueQ    <= '0;
		end
		else
		begin
			modAck      <= (stateQ == S_ARB) ? winMod : '0;
			timerAck    <= stateQ == S_ARB && simWins && tmrHit;
			edgeAck     <= stateQ == S_ARB && simWins && !tmrHit &&
				!extHit && edgeHit;
			busFaultOut <= (stateQ == S_ARB && winId == `IPA_ID_NONE) ||
				(stateQ == S_EXT && autovectorReqN && sizeAckN &&
				monCntQ >= ($bits(monCntQ))'(BUSMON_CYC - 1));
			spuriousEvt <= (stateQ == S_ARB && winId == `IPA_ID_NONE) ||
				(stateQ == S_EXT && autovectorReqN && sizeAckN &&
				(!busFaultN ||
				monCntQ >= ($bits(monCntQ))'(BUSMON_CYC - 1)));
			if (stateQ == S_FETCH && fetchDone)
				pcValueQ <= fetchData;
		end

	assign ackBus.active = stateQ == S_ACK || stateQ == S_ARB ||
		stateQ == S_EXT;
	assign ackBus.fc     = ackBus.active ? `IPA_FC_CPU : 3'h0;
	assign ackBus.addr   = ackBus.active ?
		{`IPA_ACK_HIGH, ackLevelQ, `IPA_ACK_A0} : 24'h000000;
	assign extAckCycle   = stateQ == S_EXT;
	assign fetch.req     = stateQ == S_FETCH;
	assign fetch.addr    = vbrQ + {22'h000000, vecQ, 2'h0};
	assign pcLoad        = stateQ == S_LOAD;
	assign pcValue       = pcValueQ;

	// APB slave: zero wait states, read data built in the setup cycle
	assign apbSetup = psel && !penable;
	assign apbWrite = psel && penable && pwrite;
	assign pready   = psel && penable;

	always_ff @(posedge core_clk or posedge rst)
		if (rst)
		begin
			maskQ    <= `IPA_MASK_RST;
			vbrQ     <= `IPA_VBR_RST;
			tmrLvlQ  <= `IPA_LVLREG_RST;
			tmrVecQ  <= `IPA_VEC_RST;
			edgeLvlQ <= `IPA_LVLREG_RST;
			edgeVecQ <= `IPA_VEC_RST;
			simIdQ   <= `IPA_SIMID_RST;
			modIdQ   <= {NMOD{`IPA_MODID_RST}};
		end
		else
		begin
			// The acknowledge wins over a same-cycle software write
			if (startAck)
				maskQ <= pendLvl;
			else if (apbWrite && paddr == `IPA_REG_MASK)
				maskQ <= pwdata[`IPA_LVL_MSB:0];
			if (apbWrite)
				case (paddr)
					`IPA_REG_VBR:
						vbrQ <= pwdata;
					`IPA_REG_TMR:
					begin
						tmrLvlQ <= pwdata[`IPA_LVL_MSB:0];
						tmrVecQ <= pwdata[`IPA_VEC_MSB:`IPA_VEC_LSB];
					end
					`IPA_REG_EDGE:
					begin
						edgeLvlQ <= pwdata[`IPA_LVL_MSB:0];
						edgeVecQ <= pwdata[`IPA_VEC_MSB:`IPA_VEC_LSB];
					end
					`IPA_REG_SIMID:
						simIdQ <= pwdata[`IPA_ID_W-1:0];
					`IPA_REG_MODID:
						for (int m = 0; m < NMOD; m++)
							modIdQ[m] <= pwdata[m*`IPA_ID_W +: `IPA_ID_W];
					default:
						;
				endcase
		end

	always_ff @(posedge core_clk or posedge rst)
		if (rst)
		begin
			prdata  <= '0;
			pslverr <= 1'b0;
		end
		else if (apbSetup)
		begin
			prdata  <= '0;
			pslverr <= 1'b0;
			case (paddr)
				`IPA_REG_MASK:
					prdata[`IPA_LVL_MSB:0] <= maskQ;
				`IPA_REG_VBR:
					prdata <= vbrQ;
				`IPA_REG_TMR:
					prdata <= {16'h0000, tmrVecQ, 5'h00, tmrLvlQ};
				`IPA_REG_EDGE:
					prdata <= {16'h0000, edgeVecQ, 5'h00, edgeLvlQ};
				`IPA_REG_SIMID:
					prdata[`IPA_ID_W-1:0] <= simIdQ;
				`IPA_REG_MODID:
					for (int m = 0; m < NMOD; m++)
						prdata[m*`IPA_ID_W +: `IPA_ID_W] <= modIdQ[m];
				`IPA_REG_STATUS:
				begin
					prdata[`IPA_LVL_MSB:0] <= pendLvl;
					prdata[`IPA_ST_NMI] <= nmiPendQ;
					prdata[`IPA_ST_STATE_MSB:`IPA_ST_STATE_LSB] <= stateQ;
					prdata[`IPA_ST_VEC_MSB:`IPA_ST_VEC_LSB] <= vecQ;
				end
				default:
					pslverr <= 1'b1;
			endcase
		end

	// Checks
	property p_twoSamples;
		@(posedge core_clk) disable iff (rst)
		lvlValid[3] |-> $past(rawLine[3], 1) && $past(rawLine[3], 2);
	endproperty
	a_twoSamples: assert property (p_twoSamples)
		else $error("level valid without two samples");

	property p_startAbove;
		@(posedge core_clk) disable iff (rst)
		startAck |=> stateQ == S_ACK &&
			(ackLevelQ > $past(maskQ) || ackLevelQ == `IPA_LVL_NMI);
	endproperty
	a_startAbove: assert property (p_startAbove)
		else $error("acknowledged level not above mask");

	property p_maskCopy;
		@(posedge core_clk) disable iff (rst)
		$rose(stateQ == S_ACK) |-> maskQ == ackLevelQ;
	endproperty
	a_maskCopy: assert property (p_maskCopy)
		else $error("mask not loaded with acknowledged level");

	property p_ackAddr;
		@(posedge core_clk) disable iff (rst)
		ackBus.active |-> ackBus.fc == `IPA_FC_CPU &&
			ackBus.addr[23:4] == `IPA_ACK_HIGH && ackBus.addr[0] &&
			ackBus.addr[3:1] == ackLevelQ;
	endproperty
	a_ackAddr: assert property (p_ackAddr)
		else $error("acknowledge address malformed");

	property p_nmiEdge;
		@(posedge core_clk) disable iff (rst)
		(lvlValid[7] && !valid7PrevQ) |=> nmiPendQ;
	endproperty
	a_nmiEdge: assert property (p_nmiEdge)
		else $error("level 7 edge not pending");

	property p_noContender;
		@(posedge core_clk) disable iff (rst)
		(stateQ == S_ARB && winId == `IPA_ID_NONE) |=>
			busFaultOut && spuriousEvt && vecQ == SPUR_VEC;
	endproperty
	a_noContender: assert property (p_noContender)
		else $error("missing contender not spurious");

	property p_busMon;
		@(posedge core_clk) disable iff (rst)
		$rose(stateQ == S_EXT) |-> ##[1:MON_BOUND] stateQ != S_EXT;
	endproperty
	a_busMon: assert property (p_busMon)
		else $error("external acknowledge never ended");

	property p_autoVec;
		@(posedge core_clk) disable iff (rst)
		(stateQ == S_EXT && !autovectorReqN) |=>
			vecQ == AUTO_BASE + 8'(ackLevelQ) && stateQ == S_FETCH;
	endproperty
	a_autoVec: assert property (p_autoVec)
		else $error("autovector number wrong");

	property p_vecAddr;
		@(posedge core_clk) disable iff (rst)
		fetch.req |-> fetch.addr == vbrQ + {22'h000000, vecQ, 2'h0};
	endproperty
	a_vecAddr: assert property (p_vecAddr)
		else $error("vector address wrong");

	property p_pcLoad;
		@(posedge core_clk) disable iff (rst)
		(stateQ == S_FETCH && fetchDone) |=>
			pcLoad && pcValue == $past(fetchData) ##1 stateQ == S_IDLE;
	endproperty
	a_pcLoad: assert property (p_pcLoad)
		else $error("handler address not loaded");

endmodule : ipa_arbiter

// ---- shared/ipa_cfg.svh ----
`ifndef IPA_CFG_SVH
`define IPA_CFG_SVH

// Register byte offsets
`define IPA_REG_MASK     8'h00
`define IPA_REG_VBR      8'h04
`define IPA_REG_TMR      8'h08
`define IPA_REG_EDGE     8'h0C
`define IPA_REG_SIMID    8'h10
`define IPA_REG_MODID    8'h14
`define IPA_REG_STATUS   8'h18

// Field positions
`define IPA_LVL_MSB      2
`define IPA_VEC_LSB      8
`define IPA_VEC_MSB      15
`define IPA_ID_W         4
`define IPA_ST_NMI       3
`define IPA_ST_STATE_LSB 4
`define IPA_ST_STATE_MSB 6
`define IPA_ST_VEC_LSB   8
`define IPA_ST_VEC_MSB   15

// Reset values
`define IPA_MASK_RST     3'h7
`define IPA_VBR_RST      32'h0000_0000
`define IPA_SIMID_RST    4'hF
`define IPA_MODID_RST    4'h0
`define IPA_LVLREG_RST   3'h0
`define IPA_VEC_RST      8'h0F

// Acknowledge cycle encoding
`define IPA_FC_CPU       3'h7
`define IPA_ACK_HIGH     20'hFFFFF
`define IPA_ACK_A0       1'h1

// Levels and identifiers
`define IPA_LVL_NONE     3'h0
`define IPA_LVL_NMI      3'h7
`define IPA_ID_NONE      4'h0

// Vector numbers
`define IPA_SPUR_VEC     8'h18
`define IPA_AUTO_BASE    8'h18

// Timing
`define IPA_CLK_NS       5
`define IPA_BUSMON_NS    320
`define IPA_BUSMON_CYC   ((`IPA_BUSMON_NS) / (`IPA_CLK_NS))

`endif

// ---- shared/ipa_pkg.sv ----
package ipa_pkg;

	typedef enum logic [2:0] {
		S_IDLE  = 3'h0,
		S_ACK   = 3'h1,
		S_ARB   = 3'h3,
		S_EXT   = 3'h2,
		S_FETCH = 3'h6,
		S_LOAD  = 3'h7
	} ipa_state_t;

	// Acknowledge cycle presented on the CPU-space bus
	typedef struct packed {
		logic        active;
		logic [2:0]  fc;
		logic [23:0] addr;
	} ipa_ack_t;

	// Vector table fetch request toward the core
	typedef struct packed {
		logic        req;
		logic [31:0] addr;
	} ipa_fetch_t;

endpackage : ipa_pkg

// ---- tb/ipa_core_model.sv ----
`timescale 1ns/1ps
module ipa_core_model
	import ipa_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Core fetch side
	input  wire ipa_fetch_t fetch,
	output logic            fetchDone = 1'b0,
	output logic [31:0]     fetchData = 32'h0,
	input  wire logic       slow,
	// External requester
	input  wire ipa_ack_t   ackBus,
	input  wire logic       extAckCycle,
	input  wire logic [2:0] lvl,
	input  wire logic [1:0] mode,
	input  wire logic [7:0] vec,
	output logic            sizeAckN = 1'b1,
	output logic            autovectorReqN = 1'b1,
	output logic            busFaultN = 1'b1,
	output logic [7:0]      extData = 8'h0
);
	logic [2:0] cnt;
	logic       hit;

	// Only an acknowledge naming our own level is answered
	assign hit = extAckCycle && ackBus.addr[3:1] == lvl;

	always @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			fetchDone <= 1'b0;
			cnt <= 3'h0;
			sizeAckN <= 1'b1;
			autovectorReqN <= 1'b1;
			busFaultN <= 1'b1;
		end
		else
		begin
			fetchDone <= 1'b0;
			// Idle read data keeps moving so a stale word is never taken
			fetchData <= ~fetchData;
			if (fetch.req && !fetchDone)
			begin
				if (cnt == (slow ? 3'h4 : 3'h0))
				begin
					fetchDone <= 1'b1;
					fetchData <= ~fetch.addr;
					cnt <= 3'h0;
				end
				else
					cnt <= cnt + 3'h1;
			end
			// Vector with size ack, autovector or fault
			sizeAckN <= !(hit && mode == 2'h1);
			autovectorReqN <= !(hit && mode == 2'h2);
			busFaultN <= !(hit && mode == 2'h3);
			extData <= (hit && mode == 2'h1) ? vec : ~extData;
		end
	end
endmodule : ipa_core_model

// ---- tb/tb_interrupt_priority_arbiter.sv ----
`timescale 1ns/1ps
module tb_interrupt_priority_arbiter;
	import ipa_pkg::*;
	localparam int          NM  = 2;
	localparam logic [31:0] VBR = 32'h0000_1000;
	localparam logic [31:0] RV [7] = '{7, 0, 32'hF00, 32'hF00, 32'hF, 0,
		32'h1800};
	localparam logic [2:0]  XL [3] = '{3'h5, 3'h6, 3'h1};
	localparam logic [1:0]  XM [3] = '{2'h2, 2'h3, 2'h0};
	localparam logic [7:0]  XV [3] = '{8'h1D, 8'h18, 8'h18};
	logic               core_clk = 0, rst = 1;
	logic               psel = 0, penable = 0, pwrite = 0;
	logic [7:0]         paddr = 0;
	logic [31:0]        pwdata = 0, prdata, rd, fetchData, pcValue;
	logic               pready, pslverr, err;
	logic [7:1]         extIrqN = 7'h7F;
	logic [NM-1:0]      modReq = 0, modAvec = 0, modAck;
	logic [NM-1:0][2:0] modLvl = 0;
	logic [NM-1:0][7:0] modVec = 0;
	logic               timerReq = 0, edgeReq = 0, timerAck, edgeAck;
	ipa_ack_t           ackBus, ackSeen;
	ipa_fetch_t         fetch;
	logic               extAckCycle, sizeAckN, autovectorReqN, busFaultN;
	logic               busFaultOut, spuriousEvt, fetchDone, pcLoad;
	logic               instrBoundary = 1, slow = 0, spurSeen = 0;
	logic [NM+2:0]      ackWho = 0;
	logic [7:0]         extData, xVec = 0;
	logic [2:0]         xLvl = 0;
	logic [1:0]         xMode = 0;
	int                 n_fail = 0, checks = 0;

	ipa_arbiter #(.NMOD(NM), .BUSMON_CYC(4)) dut_u (.core_clk(core_clk),
		.rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .extIrqN(extIrqN), .modReq(modReq),
		.modLvl(modLvl), .modVec(modVec), .modAvec(modAvec),
		.timerReq(timerReq), .edgeReq(edgeReq), .modAck(modAck),
		.timerAck(timerAck), .edgeAck(edgeAck), .ackBus(ackBus),
		.extAckCycle(extAckCycle), .sizeAckN(sizeAckN),
		.autovectorReqN(autovectorReqN), .busFaultN(busFaultN),
		.extData(extData), .busFaultOut(busFaultOut),
		.spuriousEvt(spuriousEvt), .instrBoundary(instrBoundary),
		.fetch(fetch), .fetchDone(fetchDone), .fetchData(fetchData),
		.pcLoad(pcLoad), .pcValue(pcValue));
	ipa_core_model model_u (.core_clk(core_clk), .rst(rst), .fetch(fetch),
		.fetchDone(fetchDone), .fetchData(fetchData), .slow(slow),
		.ackBus(ackBus), .extAckCycle(extAckCycle), .lvl(xLvl),
		.mode(xMode), .vec(xVec), .sizeAckN(sizeAckN),
		.autovectorReqN(autovectorReqN), .busFaultN(busFaultN),
		.extData(extData));

	initial
		forever #2.5 core_clk = ~core_clk;

	// Keep the last acknowledge and the pulses that followed it; a new
	// acknowledge cycle starts a fresh record
	always @(negedge core_clk)
	begin
		if (ackBus.active === 1'b1)
		begin
			ackSeen <= ackBus;
			spurSeen <= 1'b0;
			ackWho <= '0;
		end
		else
		begin
			spurSeen <= spurSeen | (spuriousEvt === 1'b1);
			ackWho <= ackWho | {modAck, timerAck, edgeAck, busFaultOut};
		end
	end

	task summarize;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the slave
		do
			@(posedge core_clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdc

	// Waits for the handler jump, then checks address, cycle and mask
	task serve(input logic [2:0] l, input logic [7:0] v);
		do
			@(negedge core_clk);
		while (pcLoad !== 1'b1);
		chk(pcValue, ~(VBR + {22'h0, v, 2'b00})); // Jump target
		chk({4'h0, ackSeen}, {5'h01, 3'h7, 20'hFFFFF, l, 1'b1});
		@(posedge core_clk);
		rdc(8'h00, {29'h0, l}); // Mask takes level
	endtask : serve

	// Nothing may be serviced for thirty cycles
	task quiet;
		logic b;
		b = 1'b0;
		repeat (30) @(negedge core_clk) b |= (pcLoad === 1'b1);
		chk({31'h0, b}, 32'h0);
		@(posedge core_clk);
	endtask : quiet

	task clr;
		modReq <= 0;
		timerReq <= 1'b0;
		edgeReq <= 1'b0;
		extIrqN <= 7'h7F;
		modAvec <= '0;
		apb(1'b1, 8'h00, 32'h0);
	endtask : clr

	initial
	begin
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		for (int i = 0; i < 7; i++)
			rdc(8'(i * 4), RV[i]); // Reset values
		apb(1'b0, 8'h1C, 32'h0);
		chk({31'h0, err}, 32'h1); // Unmapped offset refused
		apb(1'b1, 8'h04, VBR); // Table relocated
		apb(1'b1, 8'h08, 32'h3002);
		apb(1'b1, 8'h0C, 32'h3102);
		apb(1'b1, 8'h14, 32'h53);
		apb(1'b1, 8'h00, 32'h0);
		modLvl <= {3'h3, 3'h3};
		modVec <= {8'h41, 8'h40};
		modReq <= 2'b11;
		serve(3'h3, 8'h41); // Stronger id wins
		chk(32'(ackWho), 32'h10); // Only the stronger module acked
		clr;
		instrBoundary <= 1'b0;
		modLvl <= {3'h4, 3'h2};
		modReq <= 2'b01;
		repeat (3) @(posedge core_clk);
		modReq <= 2'b11;
		modAvec <= 2'b10;
		quiet; // Held until boundary
		instrBoundary <= 1'b1;
		serve(3'h4, 8'h1C); // Supersedes, autovector
		clr;
		{xLvl, xMode, xVec, slow} <= {3'h4, 2'h1, 8'h55, 1'b1};
		extIrqN[4] <= 1'b0;
		modLvl <= {3'h4, 3'h4};
		modReq <= 2'b10;
		serve(3'h4, 8'h55); // Integration id beats module
		chk(32'(ackWho), 32'h0); // No internal source acked
		clr;
		apb(1'b1, 8'h10, 32'h2);
		extIrqN[4] <= 1'b0;
		modReq <= 2'b10;
		serve(3'h4, 8'h41); // Weaker integration id loses
		chk(32'(ackWho), 32'h10); // Module acked, pins not
		apb(1'b1, 8'h10, 32'hF);
		clr;
		for (int i = 0; i < 3; i++)
		begin
			{xLvl, xMode} <= {XL[i], XM[i]};
			extIrqN <= ~(7'h01 << (XL[i] - 3'h1));
			serve(XL[i], XV[i]); // Autovector, fault, silence
			chk({31'h0, spurSeen}, {31'h0, XV[i] == 8'h18});
			chk(32'(ackWho), {31'h0, XM[i] == 2'h0}); // Monitor fault
			clr;
		end
		apb(1'b1, 8'h14, 32'h50);
		modLvl <= {3'h0, 3'h2};
		modReq <= 2'b01;
		serve(3'h2, 8'h18); // Zero id is spurious
		chk({31'h0, spurSeen}, 32'h1); // Spurious end
		chk(32'(ackWho), 32'h1); // Fault, no module acked
		clr;
		{xLvl, xMode, xVec} <= {3'h2, 2'h1, 8'h56};
		{timerReq, edgeReq} <= 2'b11;
		extIrqN[2] <= 1'b0;
		serve(3'h2, 8'h30); // Timer first
		chk(32'(ackWho), 32'h4); // Timer acked
		timerReq <= 1'b0;
		apb(1'b1, 8'h00, 32'h0);
		serve(3'h2, 8'h56); // Pins second
		extIrqN[2] <= 1'b1;
		apb(1'b1, 8'h00, 32'h0);
		serve(3'h2, 8'h31); // Edge logic last
		chk(32'(ackWho), 32'h2); // Edge logic acked
		clr;
		apb(1'b1, 8'h08, 32'h3000);
		timerReq <= 1'b1;
		modReq <= 2'b01;
		@(posedge core_clk);
		modReq <= 2'b00;
		quiet; // Level zero source and single sample ignored
		apb(1'b1, 8'h00, 32'h3);
		extIrqN[3] <= 1'b0;
		quiet; // Level at the mask ignored
		apb(1'b1, 8'h00, 32'h7);
		{xLvl, xMode} <= {3'h7, 2'h2};
		extIrqN[7] <= 1'b0;
		serve(3'h7, 8'h1F); // Edge passes full mask
		quiet; // Held low without edge ignored
		apb(1'b1, 8'h00, 32'h6);
		serve(3'h7, 8'h1F); // Mask drop retriggers
		clr;
		summarize;
	end

	initial
	begin
		#100000;
		n_fail++;
		summarize;
	end
endmodule : tb_interrupt_priority_arbiter
